// File: include/drv_pkg.sv
// constants shared by the serial-in latched driver logic
// assumes a single 50 MHz system clock; host lines arrive synchronous to it
package drv_pkg;

   // number of shift stages, latches and driver outputs
   localparam int unsigned STAGES        = 10;

   // system clock
   localparam int unsigned CLK_PERIOD_NS = 20;

   // reset values of control flops
   localparam logic        SCLK_RST      = 1'h0;
   localparam logic        RST_ACTIVE    = 1'h0;
   localparam logic        RST_RELEASED  = 1'h1;
   localparam logic        DRIVE_RST     = 1'h0;
   localparam logic        SINK_RST      = 1'h1;

endpackage : drv_pkg

// File: sim/host_lines.sv
// host model driving the serial control lines of the driver
// assumes lines are sampled by the driver on clk_i rising edges
`timescale 1ns/1ns
`default_nettype none

module host_lines (
   // clock
   input  wire logic clk_i,
   // serial control lines
   output var  logic sclk_o,
   output var  logic sdata_o,
   output var  logic strobe_o,
   output var  logic blank_o
);
   // outputs stay blanked until known data has been loaded
   initial begin
      sclk_o   = 1'h0;
      sdata_o  = 1'h0;
      strobe_o = 1'h0;
      blank_o  = 1'h1;
   end

   // one serial clock pulse, data set up while the clock is low
   task automatic shift_bit(input logic d);
      @(posedge clk_i);
      sclk_o  <= 1'b0;
      sdata_o <= d;
      if (strobe_o) begin
         blank_o <= 1'b1;
      end
      @(posedge clk_i);
      sclk_o <= 1'b1;
   endtask : shift_bit

   task automatic set_ctl(input logic s, input logic b);
      @(posedge clk_i);
      strobe_o <= s;
      blank_o  <= b;
   endtask : set_ctl
endmodule : host_lines

`default_nettype wire

// File: sim/serial_latched_driver_tb.sv
// self-checking bench of the serial-in latched driver
// assumes host_lines model and drv_pkg are compiled first
`timescale 1ns/1ns
`default_nettype none

module serial_latched_driver_tb;
   localparam int unsigned W = drv_pkg::STAGES;
   logic         clk_i  = 1'b0;
   logic         nrst_i = 1'b0;
   logic         sclk, sdata, strobe, blank, sout_o;
   logic [W-1:0] drive_o, sink_o, exp_sh, exp_lat, w;
   logic [31:0]  seed = 32'h8EDE;
   int           n_errors = 0;
   int           num_checks = 0;
   int           nb = 0;

   always #10 clk_i = ~clk_i;

   host_lines u_host (.clk_i(clk_i), .sclk_o(sclk), .sdata_o(sdata),
      .strobe_o(strobe), .blank_o(blank));
   serial_latched_driver u_dut (.clk_i(clk_i), .nrst_i(nrst_i),
      .sclk_i(sclk), .sdata_i(sdata), .strobe_i(strobe), .blank_i(blank),
      .sout_o(sout_o), .drive_o(drive_o), .sink_o(sink_o));

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs

   task automatic chk(input logic [W-1:0] got, input logic [W-1:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic chk_bit(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t serial out %b exp %b", $time, got, exp);
      end
   endtask : chk_bit

   // msb first, so after W bits the register equals the word
   task automatic send_word(input logic [W-1:0] v);
      for (int i = W - 1; i >= 0; i--) begin
         u_host.shift_bit(v[i]);
         exp_sh = {exp_sh[W-2:0], v[i]};
         nb++;
         @(posedge clk_i);
         #1;
         if (nb >= W) chk_bit(sout_o, exp_sh[W-1]);
      end
   endtask : send_word

   task automatic outs(input logic b);
      chk(drive_o, b ? '0 : exp_lat);
      chk(sink_o, b ? '1 : ~exp_lat);
   endtask : outs

   task automatic settle(input logic b);
      repeat (2) @(posedge clk_i);
      #1 outs(b);
   endtask : settle

   task automatic print_verdict;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : print_verdict

   initial begin
      #100000;
      n_errors++;
      print_verdict();
   end

   // -------------------------------------------------------------
   // test sequence
   // -------------------------------------------------------------
   initial begin
      exp_sh = '0;
      repeat (4) @(posedge clk_i);
      nrst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      #1 outs(1'b1);
      $display("test reset done");
      for (int f = 0; f < 5; f++) begin
         seed = xs(seed);
         w = (f == 0) ? '1 : (f == 1) ? 10'h2AA : seed[W-1:0];
         send_word(w);
         u_host.set_ctl(1'b1, 1'b0);
         u_host.set_ctl(1'b0, 1'b0);
         exp_lat = exp_sh;
         settle(1'b0);
         chk(drive_o, w);
      end
      $display("test load done");
      seed = xs(seed);
      send_word(seed[W-1:0]);
      settle(1'b0);
      $display("test hold done");
      u_host.set_ctl(1'b0, 1'b1);
      settle(1'b1);
      u_host.set_ctl(1'b0, 1'b0);
      settle(1'b0);
      $display("test blank done");
      u_host.set_ctl(1'b1, 1'b1);
      seed = xs(seed);
      send_word(seed[W-1:0]);
      #1 outs(1'b1);
      u_host.set_ctl(1'b1, 1'b0);
      exp_lat = exp_sh;
      settle(1'b0);
      $display("test transparent done");
      print_verdict();
   end
endmodule : serial_latched_driver_tb

`default_nettype wire

// File: src/latch_bank.sv
// bank of level-controlled holding latches, one per shift stage
// assumes load_i is synchronous to clk_i; contents are not reset
`timescale 1ns/1ns
`default_nettype none

module latch_bank #(
   parameter int unsigned WIDTH = drv_pkg::STAGES
) (
   // clock
   input  wire logic             clk_i,
   // load control and data
   input  wire logic             load_i,
   input  wire logic [WIDTH-1:0] d_i,
   // held contents
   output logic      [WIDTH-1:0] q_o
);

   // refuse a bank without stages at elaboration
   if (WIDTH < 1) begin : g_width_check
      $error("latch_bank: WIDTH must be at least 1");
   end

   // ----------------------------------------------------------------
   // one latch per stage
   // ----------------------------------------------------------------
   logic [WIDTH-1:0] q_r;
   logic [WIDTH-1:0] q_nxt;

   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         always_comb begin
            q_nxt[g] = load_i ? d_i[g] : q_r[g];
         end

         always_ff @(posedge clk_i) begin
            q_r[g] <= q_nxt[g];
         end
      end
   endgenerate

   assign q_o = q_r;

endmodule : latch_bank

`default_nettype wire

// File: src/serial_latched_driver.sv
// logic of a serial-input, latched output driver with blanking
// assumes sclk_i, sdata_i, strobe_i and blank_i are synchronous to clk_i
// and that the host keeps each sclk_i level for at least one clk_i cycle
//
// Function
// - ten shift stages, latches and outputs each
// - serial input captured on serial clock rise
// - stages shift forward; last stage cascades out
// - strobe high copies stages; low holds latches
// - latches stay transparent while strobe stays high
// - blanking forces every output low, sinks on
// - blanking never disturbs stored latch contents
// - unblanked outputs follow their own latch
`timescale 1ns/1ns
`default_nettype none

module serial_latched_driver #(
   parameter int unsigned WIDTH = drv_pkg::STAGES
) (
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             nrst_i,
   // host serial lines
   input  wire logic             sclk_i,
   input  wire logic             sdata_i,
   input  wire logic             strobe_i,
   input  wire logic             blank_i,
   // cascade serial output
   output logic                  sout_o,
   // driver controls: source on per output, pull-down on per output
   output logic      [WIDTH-1:0] drive_o,
   output logic      [WIDTH-1:0] sink_o
);

   // the shift path needs at least two stages
   if (WIDTH < 2) begin : g_width_check
      $error("serial_latched_driver: WIDTH must be at least 2");
   end

   // ----------------------------------------------------------------
   // reset release through two flops
   // ----------------------------------------------------------------
   logic rst_meta_r;
   logic rst_n_r;

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rst_meta_r <= drv_pkg::RST_ACTIVE;
         rst_n_r    <= drv_pkg::RST_ACTIVE;
      end else begin
         rst_meta_r <= drv_pkg::RST_RELEASED;
         rst_n_r    <= rst_meta_r;
      end
   end

   // ----------------------------------------------------------------
   // serial clock rise detection
   // ----------------------------------------------------------------
   logic sclk_prev_r;
   logic sclk_prev_nxt;
   logic rise;

   always_comb begin
      sclk_prev_nxt = sclk_i;
      rise          = sclk_i & ~sclk_prev_r;
   end

   always_ff @(posedge clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         sclk_prev_r <= drv_pkg::SCLK_RST;
      end else begin
         sclk_prev_r <= sclk_prev_nxt;
      end
   end

   // ----------------------------------------------------------------
   // shift register
   // ----------------------------------------------------------------
   // stage contents are deliberately not reset: the host must shift in
   // and strobe known data before the outputs mean anything
   logic [WIDTH-1:0] shift_r;
   logic [WIDTH-1:0] shift_nxt;

   always_comb begin
      if (rise) begin
         shift_nxt = {shift_r[WIDTH-2:0], sdata_i};
      end else begin
         shift_nxt = shift_r;
      end
   end

   always_ff @(posedge clk_i) begin
      shift_r <= shift_nxt;
   end

   // last stage goes straight out for cascading
   assign sout_o = shift_r[WIDTH-1];

   // ----------------------------------------------------------------
   // latches
   // ----------------------------------------------------------------
   // the bank samples the stages on every cycle that strobe is high, so
   // shifting under a high strobe keeps flowing into the latches;
   // blanking has no path into the bank at all
   logic [WIDTH-1:0] latch_q;

   latch_bank #(
      .WIDTH (WIDTH)
   ) u_latch (
      .clk_i  (clk_i),
      .load_i (strobe_i),
      .d_i    (shift_r),
      .q_o    (latch_q)
   );

   // ----------------------------------------------------------------
   // output drivers
   // ----------------------------------------------------------------
   // with strobe tied high the outputs would show partial data while
   // shifting; the host covers that by blanking meanwhile
   logic [WIDTH-1:0] drive_r;
   logic [WIDTH-1:0] drive_nxt;
   logic [WIDTH-1:0] sink_r;
   logic [WIDTH-1:0] sink_nxt;

   always_comb begin
      if (blank_i) begin
         drive_nxt = '0;
         sink_nxt  = '1;
      end else begin
         drive_nxt = latch_q;
         sink_nxt  = ~latch_q;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         drive_r <= {WIDTH{drv_pkg::DRIVE_RST}};
         sink_r  <= {WIDTH{drv_pkg::SINK_RST}};
      end else begin
         drive_r <= drive_nxt;
         sink_r  <= sink_nxt;
      end
   end

   assign drive_o = drive_r;
   assign sink_o  = sink_r;

   // ----------------------------------------------------------------
   // assertion helpers
   // ----------------------------------------------------------------
   // stages and latches power up undefined; checks that compare stored
   // data wait until those bits have really been shifted in and strobed
   logic [WIDTH-1:0] known_r;
   logic [WIDTH-1:0] known_nxt;
   logic             loaded_r;
   logic             loaded_nxt;

   always_comb begin
      known_nxt  = known_r;
      loaded_nxt = loaded_r;
      if (rise) begin
         known_nxt = {known_r[WIDTH-2:0], 1'h1};
      end
      if (strobe_i && known_r[WIDTH-1]) begin
         loaded_nxt = 1'h1;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         known_r  <= '0;
         loaded_r <= 1'h0;
      end else begin
         known_r  <= known_nxt;
         loaded_r <= loaded_nxt;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   sequence s_strobe_shift;
      strobe_i && rise && known_r[WIDTH-2];
   endsequence

   sequence s_strobe_stays;
      strobe_i [*2];
   endsequence

   shift_in_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_r)
      rise |=> shift_r[0] == $past(sdata_i))
      else $error("first stage missed serial data on clock rise");

   shift_move_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_r)
      rise && known_r[WIDTH-2] |=>
         shift_r[WIDTH-1:1] == $past(shift_r[WIDTH-2:0]))
      else $error("stages did not shift forward on clock rise");

   shift_hold_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_r)
      !rise && known_r[WIDTH-1] |=> shift_r == $past(shift_r))
      else $error("shift register moved without a clock rise");

   cascade_out_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_r)
      rise && known_r[WIDTH-2] |=> sout_o == $past(shift_r[WIDTH-2]))
      else $error("cascade output did not advance with the shift");

   latch_load_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_r)
      strobe_i && known_r[WIDTH-1] |=> latch_q == $past(shift_r))
      else $error("latches did not copy stages under strobe");

   latch_hold_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_r)
      !strobe_i && loaded_r |=> $stable(latch_q))
      else $error("latches changed with strobe low");

   latch_flow_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_r)
      s_strobe_shift ##0 s_strobe_stays |=>
         latch_q == {$past(shift_r[WIDTH-2:0], 2), $past(sdata_i, 2)})
      else $error("shifted data did not flow through open latches");

   blank_force_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_r)
      blank_i |=> (drive_o == '0) && (sink_o == '1))
      else $error("blanking did not force outputs low");

   blank_keep_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_r)
      $changed(blank_i) && !strobe_i && loaded_r |=> $stable(latch_q))
      else $error("blanking edge disturbed latch contents");

   follow_latch_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_r)
      !blank_i && loaded_r |=>
         (drive_o == $past(latch_q)) && (sink_o == ~drive_o))
      else $error("unblanked outputs do not follow latches");

endmodule : serial_latched_driver

`default_nettype wire
